/* pkg/lfs_fb_if.sv */
// link between the supervisor and one command/feedback monitor
`timescale 1ns/100ps
`default_nettype none
interface lfs_fb_if;
   logic tick;
   logic enable;
   logic drive;
   logic fb;
   logic fault;
   modport sup (output tick, output enable, output drive, output fb, input fault);
   modport mon (input tick, input enable, input drive, input fb, output fault);
endinterface
`default_nettype wire

/* pkg/lfs_map.svh */
// constants of the lift fault supervisor: timing, codes, event positions, encoder check defaults
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH

// supervision tick
`define LFS_CLK_PERIOD_NS 10
`define LFS_TICK_NS 1000000
`define LFS_TICK_MS 1
`define LFS_TICK_CYCLES (`LFS_TICK_NS / `LFS_CLK_PERIOD_NS)

// feedback and watchdog times, in milliseconds, and their tick counts
`define LFS_BRAKE_A_MS 500
`define LFS_BRAKE_B_MS 2000
`define LFS_CONTACTOR_MS 400
`define LFS_DRIVE_WAIT_MS 500
`define LFS_BRAKE_A_TICKS (`LFS_BRAKE_A_MS / `LFS_TICK_MS)
`define LFS_BRAKE_B_TICKS (`LFS_BRAKE_B_MS / `LFS_TICK_MS)
`define LFS_CONTACTOR_TICKS (`LFS_CONTACTOR_MS / `LFS_TICK_MS)
`define LFS_DRIVE_WAIT_TICKS (`LFS_DRIVE_WAIT_MS / `LFS_TICK_MS)

// displayed fault codes
`define LFS_CODE_NONE 8'h00
`define LFS_CODE_DOOR 8'h02
`define LFS_CODE_DRIVE 8'h03
`define LFS_CODE_DIR 8'h04
`define LFS_CODE_BRAKE 8'h05
`define LFS_CODE_ZONE 8'h06
`define LFS_CODE_PULSE 8'h07
`define LFS_CODE_CONT 8'h09
`define LFS_CODE_SAFETY 8'h0a
`define LFS_CODE_LEVEL 8'h0b
`define LFS_CODE_TOP 8'h0c
`define LFS_CODE_BOTTOM 8'h0d
`define LFS_CODE_COUNT 8'h0e
`define LFS_CODE_NODRIVE 8'h11
`define LFS_CODE_FLOOR 8'h12

// event vector positions; 0..6 come from level conditions
`define LFS_EV_DOOR 0
`define LFS_EV_DRIVE 1
`define LFS_EV_SAFETY 2
`define LFS_EV_TOP 3
`define LFS_EV_BOTTOM 4
`define LFS_EV_FLOOR 5
`define LFS_EV_NODRIVE 6
`define LFS_EV_DIR 7
`define LFS_EV_BRAKE 8
`define LFS_EV_ZONE 9
`define LFS_EV_PULSE 10
`define LFS_EV_CONT 11
`define LFS_EV_LEVEL 12
`define LFS_EV_COUNT 13
`define LFS_NUM_COND 7
`define LFS_NUM_EV 14

// defaults of the encoder checks
`define LFS_PULSES_PER_FLOOR 1024
`define LFS_PULSE_TOL 32
`define LFS_DIR_ERR_PULSES 4
`define LFS_NUM_FLOORS 16

`endif

/* pkg/lfs_pkg.sv */
// types of the lift fault supervisor
package lfs_pkg;

   typedef enum logic {RC_IDLE, RC_RUN} lfs_recal_t;

   typedef struct packed {
      logic [19:0] tick_cnt;
      logic [6:0] cond_q;
      logic run_q;
      logic [15:0] run_pulses;
      logic [15:0] floor_pulses;
      logic seen_floor;
      logic zone_q;
      logic zone_stuck;
      logic [3:0] dir_err;
      logic [11:0] drive_wait;
      logic [7:0] code;
      logic active;
      lfs_recal_t recal;
   } lfs_sup_st_t;

   typedef struct packed {
      logic [11:0] cnt;
      logic done;
      logic mis_q;
      logic fault;
   } lfs_mon_st_t;

endpackage

/* testbench/lfs_partner.sv */
// partner model: brake contacts, star-delta contactor contact, encoder
`timescale 1ns/100ps
`default_nettype none
module lfs_partner (
   // clock and commands seen
   input wire logic sys_clk,
   input wire logic brake_release_out,
   input wire logic contactor_drive_out,
   input wire logic car_running,
   input wire logic cmd_up,
   // scenario controls: delays in cycles, welded contacts, swapped encoder
   input wire logic [15:0] dly_a,
   input wire logic [15:0] dly_b,
   input wire logic [15:0] dly_c,
   input wire logic [1:0] stuck,
   input wire logic enc_rev,
   // contacts and encoder
   output logic brake_feedback_a,
   output logic brake_feedback_b,
   output logic contactor_feedback_in,
   output logic enc_pulse,
   output logic enc_dir_up
);
   logic [15:0] cb_ff;
   logic [15:0] cc_ff;
   always_ff @(posedge sys_clk) begin
      cb_ff <= brake_release_out ? cb_ff + 16'h0001 : 16'h0000;
      cc_ff <= contactor_drive_out ? cc_ff + 16'h0001 : 16'h0000;
      enc_pulse <= car_running & ~enc_pulse;
   end
   // a delay of ffff answers only after 65535 cycles of command, the slow contact case
   assign brake_feedback_a = stuck[0] | (brake_release_out && cb_ff >= dly_a);
   assign brake_feedback_b = stuck[0] | (brake_release_out && cb_ff >= dly_b);
   assign contactor_feedback_in = stuck[1] | (contactor_drive_out && cc_ff >= dly_c);
   assign enc_dir_up = cmd_up ^ enc_rev;
endmodule
`default_nettype wire

/* testbench/tb_lift_fault_supervisor.sv */
// self-checking bench of the lift fault supervisor
`timescale 1ns/100ps
`default_nettype none
`include "lfs_map.svh"
module tb_lift_fault_supervisor;
   import lfs_pkg::*;
   logic sys_clk, arst_n, car_running, run_cmd, cmd_up, drive_active_in, drive_fault_in;
   logic enc_pulse, enc_dir_up, door_lock_in, level_switch_up, level_switch_down;
   logic top_limit_in, bottom_limit_in, bottom_floor_in, safety_loop_in_a, safety_loop_in_b;
   logic brake_release_out, brake_feedback_a, brake_feedback_b, brake_fb_enable;
   logic contactor_drive_out, contactor_feedback_in, fault_clear, fault_active, recal_req;
   logic enc_rev;
   logic [1:0] stuck;
   logic [7:0] floor_number, fault_code;
   logic [15:0] expected_pulses, dly_a, dly_b, dly_c;
   int fail_count = 0;
   int n_checks = 0;
   lfs_supervisor #(.TICK_CYCLES(10)) uut (.sys_clk, .arst_n, .car_running, .run_cmd,
      .cmd_up, .drive_active_in, .drive_fault_in, .enc_pulse, .enc_dir_up, .expected_pulses,
      .door_lock_in, .level_switch_up, .level_switch_down, .top_limit_in, .bottom_limit_in,
      .bottom_floor_in, .floor_number, .safety_loop_in_a, .safety_loop_in_b,
      .brake_release_out, .brake_feedback_a, .brake_feedback_b, .brake_fb_enable,
      .contactor_drive_out, .contactor_feedback_in, .fault_clear, .fault_code, .fault_active,
      .recal_req);
   lfs_partner far (.sys_clk, .brake_release_out, .contactor_drive_out, .car_running,
      .cmd_up, .dly_a, .dly_b, .dly_c, .stuck, .enc_rev, .brake_feedback_a, .brake_feedback_b,
      .contactor_feedback_in, .enc_pulse, .enc_dir_up);
   // ---------------------------------
   // helpers
   // ---------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // answers land one or two cycles after the cause
   task automatic wait_code(input logic [7:0] exp, input int lim);
      for (int i = 0; i < lim && fault_code !== exp; i++) @(negedge sys_clk);
      chk(fault_code, exp);
   endtask
   task automatic clr;
      fault_clear = 1'b1;
      cyc(1);
      fault_clear = 1'b0;
      cyc(1);
      chk({7'h00, fault_active}, 8'h00);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ---------------------------------
   // scenarios
   // ---------------------------------
   task automatic t_latch;
      drive_fault_in = 1'b1;
      wait_code(`LFS_CODE_DRIVE, 3);
      {safety_loop_in_a, safety_loop_in_b} = 2'b00;
      wait_code(`LFS_CODE_SAFETY, 3);
      {safety_loop_in_a, safety_loop_in_b, drive_fault_in} = 3'b110;
      clr();
      top_limit_in = 1'b0;
      wait_code(`LFS_CODE_TOP, 3);
      top_limit_in = 1'b1;
      bottom_limit_in = 1'b0;
      wait_code(`LFS_CODE_BOTTOM, 3);
      bottom_limit_in = 1'b1;
      clr();
   endtask
   task automatic t_door;
      car_running = 1'b1;
      cyc(4);
      door_lock_in = 1'b0;
      wait_code(`LFS_CODE_DOOR, 3);
      door_lock_in = 1'b1;
      car_running = 1'b0;
      cyc(2);
      clr();
   endtask
   task automatic t_contacts;
      brake_fb_enable = 1'b0;
      stuck = 2'b01;
      cyc(20);
      chk(fault_code, 8'h00);
      brake_fb_enable = 1'b1;
      wait_code(`LFS_CODE_BRAKE, 4);
      stuck = 2'b11;
      wait_code(`LFS_CODE_CONT, 4);
      stuck = 2'b00;
      clr();
   endtask
   // every feedback and the drive answer in time: nothing may be raised
   task automatic t_quiet;
      {dly_a, dly_b, dly_c} = {16'h0064, 16'h03e8, 16'h012c};
      {run_cmd, drive_active_in, contactor_drive_out, brake_release_out} = 4'hf;
      cyc(5200);
      chk(fault_code, 8'h00);
      {run_cmd, drive_active_in, contactor_drive_out, brake_release_out} = 4'h0;
      cyc(2);
      chk(fault_code, 8'h00);
   endtask
   // sel picks one of brake release, contactor drive, run command
   task automatic t_late(input logic [2:0] sel, input logic [15:0] da, input logic [15:0] db,
                         input logic [15:0] dc, input int ticks, input logic [7:0] code);
      {dly_a, dly_b, dly_c} = {da, db, dc};
      {run_cmd, contactor_drive_out, brake_release_out} = sel;
      cyc(ticks * 10 - 20);
      chk(fault_code, 8'h00);
      wait_code(code, 40);
      {run_cmd, contactor_drive_out, brake_release_out} = 3'b000;
      cyc(2);
      clr();
   endtask
   task automatic t_run(input int n, input logic rev, input logic zone, input logic [15:0] ep,
                        input logic [7:0] code);
      {enc_rev, expected_pulses} = {rev, ep};
      {level_switch_up, level_switch_down} = {zone, zone};
      cyc(2);
      car_running = 1'b1;
      cyc(n);
      car_running = 1'b0;
      wait_code(code, 4);
      {enc_rev, level_switch_up, level_switch_down} = 3'b000;
      clr();
   endtask
   task automatic t_recal(input logic drift);
      bottom_floor_in = 1'b0;
      car_running = drift;
      cyc(100);
      {level_switch_up, level_switch_down} = {drift, drift};
      cyc(2);
      {level_switch_up, level_switch_down} = 2'b00;
      cyc(200);
      {level_switch_up, level_switch_down} = {drift, drift};
      floor_number = drift ? 8'h00 : 8'h10;
      wait_code(drift ? `LFS_CODE_COUNT : `LFS_CODE_FLOOR, 4);
      cyc(1);
      chk({7'h00, recal_req}, 8'h01);
      {level_switch_up, level_switch_down, car_running} = 3'b000;
      floor_number = 8'h00;
      bottom_floor_in = 1'b1;
      cyc(3);
      chk({7'h00, recal_req}, 8'h00);
      clr();
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #700_000;
      fail_count++;
      wrap_up();
   end
   initial begin
      {arst_n, car_running, run_cmd, drive_active_in, drive_fault_in, enc_rev} = 6'h00;
      {cmd_up, door_lock_in, top_limit_in, bottom_limit_in, bottom_floor_in} = 5'h1f;
      {level_switch_up, level_switch_down, safety_loop_in_a, safety_loop_in_b} = 4'h3;
      {brake_release_out, brake_fb_enable, contactor_drive_out, fault_clear} = 4'h4;
      {floor_number, expected_pulses, stuck} = 26'h000_0000;
      {dly_a, dly_b, dly_c} = 48'h0000_0000_0000;
      cyc(4);
      arst_n = 1'b1;
      cyc(3);
      chk(fault_code, 8'h00);
      t_latch();
      t_door();
      t_contacts();
      t_quiet();
      t_late(3'b001, 16'hffff, 16'h0000, 16'h0000, 500, `LFS_CODE_BRAKE);
      t_late(3'b001, 16'h0000, 16'hffff, 16'h0000, 2000, `LFS_CODE_BRAKE);
      t_late(3'b010, 16'h0000, 16'h0000, 16'hffff, 400, `LFS_CODE_CONT);
      t_late(3'b100, 16'h0000, 16'h0000, 16'h0000, 500, `LFS_CODE_NODRIVE);
      cmd_up = 1'b0;
      t_run(40, 1'b1, 1'b0, 16'h0000, `LFS_CODE_DIR);
      t_run(40, 1'b0, 1'b0, 16'h0010, 8'h00);
      t_run(40, 1'b0, 1'b0, 16'h0100, `LFS_CODE_PULSE);
      t_run(40, 1'b0, 1'b1, 16'h0000, `LFS_CODE_ZONE);
      t_run(2300, 1'b0, 1'b0, 16'h0000, `LFS_CODE_LEVEL);
      t_recal(1'b1);
      t_recal(1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire

/* verilog/lfs_fb_mon.sv */
// command versus feedback monitor: late feedback and feedback without command
`timescale 1ns/100ps
`default_nettype none
module lfs_fb_mon
   import lfs_pkg::*;
#(
   parameter int unsigned TIMEOUT_TICKS = 500
) (
   // clock and synchronised reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // supervisor side
   lfs_fb_if.mon mon
);
   import lfs_pkg::*;

   localparam logic [11:0] TO_M1 = 12'(TIMEOUT_TICKS - 1);

   if (TIMEOUT_TICKS < 1 || TIMEOUT_TICKS > 4095) begin : g_bad_timeout
      $error("timeout out of range of the tick counter");
   end

   lfs_mon_st_t st_ff;
   lfs_mon_st_t nxt_st;
   logic mis;

   // feedback showing while nothing is commanded
   assign mis = mon.enable && mon.fb && !mon.drive;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.fault = 1'b0;
      if (!mon.drive || mon.fb || !mon.enable) begin
         nxt_st.cnt = '0;
         if (!mon.drive) begin
            nxt_st.done = 1'b0;
         end
      end else if (mon.tick && !st_ff.done) begin
         // one report per command; the counter parks until the command drops
         if (st_ff.cnt == TO_M1) begin
            nxt_st.fault = 1'b1;
            nxt_st.done = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 12'h001;
         end
      end
      if (mis && !st_ff.mis_q) begin
         nxt_st.fault = 1'b1;
      end
      nxt_st.mis_q = mis;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign mon.fault = st_ff.fault;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_late_feedback: assert property (
      mon.tick && mon.drive && mon.enable && !mon.fb && !st_ff.done && st_ff.cnt == TO_M1
      |=> mon.fault)
      else $error("missing feedback not reported at timeout");
   chk_spurious_feedback: assert property (
      $rose(mon.enable && mon.fb && !mon.drive) |=> mon.fault)
      else $error("feedback without command not reported");
   chk_disabled_quiet: assert property (
      !mon.enable |=> !mon.fault)
      else $error("fault reported while checking is off");

endmodule
`default_nettype wire

/* verilog/lfs_supervisor.sv */
// lift fault supervisor: watches hoistway, safety, brake, contactor and encoder
`timescale 1ns/100ps
`default_nettype none
`include "lfs_map.svh"
// Notes on behaviour
// - door interlock open while running gives 2
// - encoder direction against command gives 4
// - brake feedback late, 0.5/2 s, gives 5
// - brake feedback without release command gives 5
// - brake feedback checking can be switched off
// - leveling zone stuck whole run gives 6
// - too few encoder pulses in run gives 7
// - contactor feedback missing after 0.4 s gives 9
// - contactor feedback without drive gives 9
// - both safety inputs inactive gives 10
// - floor passed without leveling zone gives 11
// - top limit input inactive gives 12
// - bottom limit input inactive gives 13
// - floor count drift gives 14, recalibrate
// - no drive output after run command gives 17
// - invalid floor number gives 18, recalibrate
// - any drive internal fault gives 3
module lfs_supervisor
   import lfs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `LFS_TICK_CYCLES,
   parameter int unsigned PULSES_PER_FLOOR = `LFS_PULSES_PER_FLOOR,
   parameter int unsigned PULSE_TOL = `LFS_PULSE_TOL,
   parameter int unsigned DIR_ERR_PULSES = `LFS_DIR_ERR_PULSES,
   parameter int unsigned NUM_FLOORS = `LFS_NUM_FLOORS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // running state and commands
   input wire logic car_running,
   input wire logic run_cmd,
   input wire logic cmd_up,
   input wire logic drive_active_in,
   input wire logic drive_fault_in,
   // encoder
   input wire logic enc_pulse,
   input wire logic enc_dir_up,
   input wire logic [15:0] expected_pulses,
   // hoistway
   input wire logic door_lock_in,
   input wire logic level_switch_up,
   input wire logic level_switch_down,
   input wire logic top_limit_in,
   input wire logic bottom_limit_in,
   input wire logic bottom_floor_in,
   input wire logic [7:0] floor_number,
   // safety loop
   input wire logic safety_loop_in_a,
   input wire logic safety_loop_in_b,
   // brake and star-delta contactor
   input wire logic brake_release_out,
   input wire logic brake_feedback_a,
   input wire logic brake_feedback_b,
   input wire logic brake_fb_enable,
   input wire logic contactor_drive_out,
   input wire logic contactor_feedback_in,
   // display and recalibration
   input wire logic fault_clear,
   output logic [7:0] fault_code,
   output logic fault_active,
   output logic recal_req
);
   import lfs_pkg::*;

   // ----------------------------------------------------------------
   // constants and elaboration checks
   // ----------------------------------------------------------------
   localparam logic [19:0] TICK_M1 = 20'(TICK_CYCLES - 1);
   localparam logic [15:0] PPF = 16'(PULSES_PER_FLOOR);
   localparam logic [15:0] TOL = 16'(PULSE_TOL);
   localparam logic [15:0] MISS_M1 = 16'(PULSES_PER_FLOOR + PULSE_TOL - 1);
   localparam logic [3:0] DIR_M1 = 4'(DIR_ERR_PULSES - 1);
   localparam logic [7:0] FLOORS = 8'(NUM_FLOORS);
   localparam logic [11:0] DRV_TICKS = 12'(`LFS_DRIVE_WAIT_TICKS);

   if (TICK_CYCLES < 2 || TICK_CYCLES > 1048576) begin : g_bad_tick
      $error("tick divider out of range");
   end
   if (PULSES_PER_FLOOR + PULSE_TOL > 65535 || PULSE_TOL >= PULSES_PER_FLOOR)
   begin : g_bad_pulses
      $error("floor pulse window does not fit the counters");
   end
   if (DIR_ERR_PULSES < 1 || DIR_ERR_PULSES > 15) begin : g_bad_dir
      $error("direction filter out of range");
   end
   if (NUM_FLOORS < 2 || NUM_FLOORS > 255) begin : g_bad_floors
      $error("floor count out of range");
   end

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic rst_n;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
   endfunction

   function automatic logic off_window(input logic [15:0] cnt);
      logic [15:0] diff;
      diff = (cnt > PPF) ? cnt - PPF : PPF - cnt;
      off_window = diff > TOL;
   endfunction

   // later positions win, so a simultaneous pair shows the higher one
   function automatic logic [7:0] pick_code(input logic [`LFS_NUM_EV-1:0] ev);
      logic [7:0] c;
      c = `LFS_CODE_NONE;
      for (int i = 0; i < `LFS_NUM_EV; i++) begin
         if (ev[i]) begin
            case (i)
               `LFS_EV_DOOR: c = `LFS_CODE_DOOR;
               `LFS_EV_DRIVE: c = `LFS_CODE_DRIVE;
               `LFS_EV_SAFETY: c = `LFS_CODE_SAFETY;
               `LFS_EV_TOP: c = `LFS_CODE_TOP;
               `LFS_EV_BOTTOM: c = `LFS_CODE_BOTTOM;
               `LFS_EV_FLOOR: c = `LFS_CODE_FLOOR;
               `LFS_EV_NODRIVE: c = `LFS_CODE_NODRIVE;
               `LFS_EV_DIR: c = `LFS_CODE_DIR;
               `LFS_EV_BRAKE: c = `LFS_CODE_BRAKE;
               `LFS_EV_ZONE: c = `LFS_CODE_ZONE;
               `LFS_EV_PULSE: c = `LFS_CODE_PULSE;
               `LFS_EV_CONT: c = `LFS_CODE_CONT;
               `LFS_EV_LEVEL: c = `LFS_CODE_LEVEL;
               `LFS_EV_COUNT: c = `LFS_CODE_COUNT;
               default: c = `LFS_CODE_NONE;
            endcase
         end
      end
      pick_code = c;
   endfunction

   // ----------------------------------------------------------------
   // state and feedback monitors
   // ----------------------------------------------------------------
   lfs_sup_st_t st_ff;
   lfs_sup_st_t nxt_st;
   logic tick;
   logic zone;
   logic zone_rise;
   logic run_start;
   logic run_end;
   logic wrong_dir;
   logic [`LFS_NUM_COND-1:0] cond;
   logic [`LFS_NUM_EV-1:0] ev;

   lfs_fb_if brk_a ();
   lfs_fb_if brk_b ();
   lfs_fb_if cont ();

   assign brk_a.tick = tick;
   assign brk_a.enable = brake_fb_enable;
   assign brk_a.drive = brake_release_out;
   assign brk_a.fb = brake_feedback_a;
   assign brk_b.tick = tick;
   assign brk_b.enable = brake_fb_enable;
   assign brk_b.drive = brake_release_out;
   assign brk_b.fb = brake_feedback_b;
   // no switch-off for the contactor check
   assign cont.tick = tick;
   assign cont.enable = 1'b1;
   assign cont.drive = contactor_drive_out;
   assign cont.fb = contactor_feedback_in;

   lfs_fb_mon #(.TIMEOUT_TICKS(`LFS_BRAKE_A_TICKS)) u_brk_a (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .mon(brk_a.mon)
   );
   lfs_fb_mon #(.TIMEOUT_TICKS(`LFS_BRAKE_B_TICKS)) u_brk_b (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .mon(brk_b.mon)
   );
   lfs_fb_mon #(.TIMEOUT_TICKS(`LFS_CONTACTOR_TICKS)) u_cont (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .mon(cont.mon)
   );

   // ----------------------------------------------------------------
   // fault detection
   // ----------------------------------------------------------------
   assign tick = st_ff.tick_cnt == TICK_M1;
   assign zone = level_switch_up && level_switch_down;
   assign zone_rise = car_running && zone && !st_ff.zone_q;
   assign run_start = car_running && !st_ff.run_q;
   assign run_end = st_ff.run_q && !car_running;
   assign wrong_dir = car_running && enc_pulse && (enc_dir_up != cmd_up);

   // level conditions report once, on their leading edge
   assign cond[`LFS_EV_DOOR] = car_running && !door_lock_in;
   assign cond[`LFS_EV_DRIVE] = drive_fault_in;
   assign cond[`LFS_EV_SAFETY] = !safety_loop_in_a && !safety_loop_in_b;
   assign cond[`LFS_EV_TOP] = !top_limit_in;
   assign cond[`LFS_EV_BOTTOM] = !bottom_limit_in;
   assign cond[`LFS_EV_FLOOR] = floor_number >= FLOORS;
   assign cond[`LFS_EV_NODRIVE] = st_ff.drive_wait == DRV_TICKS;

   assign ev[`LFS_NUM_COND-1:0] = cond & ~st_ff.cond_q;
   assign ev[`LFS_EV_DIR] = wrong_dir && st_ff.dir_err == DIR_M1;
   assign ev[`LFS_EV_BRAKE] = brk_a.fault || brk_b.fault;
   assign ev[`LFS_EV_ZONE] = run_end && st_ff.zone_stuck;
   assign ev[`LFS_EV_PULSE] = run_end && st_ff.run_pulses < expected_pulses;
   assign ev[`LFS_EV_CONT] = cont.fault;
   assign ev[`LFS_EV_LEVEL] = car_running && enc_pulse && !zone_rise
      && st_ff.floor_pulses == MISS_M1;
   assign ev[`LFS_EV_COUNT] = zone_rise && st_ff.seen_floor
      && off_window(st_ff.floor_pulses);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick_cnt = tick ? 20'h0_0000 : st_ff.tick_cnt + 20'h0_0001;
      nxt_st.cond_q = cond;
      nxt_st.run_q = car_running;
      nxt_st.zone_q = zone;

      // pulses per run and per floor
      if (run_start) begin
         nxt_st.run_pulses = 16'h0000;
      end else if (car_running && enc_pulse) begin
         nxt_st.run_pulses = sat_inc(st_ff.run_pulses);
      end
      if (run_start || zone_rise) begin
         nxt_st.floor_pulses = 16'h0000;
      end else if (car_running && enc_pulse) begin
         nxt_st.floor_pulses = sat_inc(st_ff.floor_pulses);
      end
      // first floor interval of a run starts mid-zone, so it is not measured
      if (run_start) begin
         nxt_st.seen_floor = 1'b0;
      end else if (zone_rise) begin
         nxt_st.seen_floor = 1'b1;
      end
      if (run_start) begin
         nxt_st.zone_stuck = zone;
      end else if (car_running && !zone) begin
         nxt_st.zone_stuck = 1'b0;
      end

      // a few consecutive wrong pulses during a run filter encoder jitter
      if (!car_running) begin
         nxt_st.dir_err = 4'h0;
      end else if (car_running && enc_pulse) begin
         if (!wrong_dir) begin
            nxt_st.dir_err = 4'h0;
         end else if (st_ff.dir_err != DIR_M1 + 4'h1) begin
            nxt_st.dir_err = st_ff.dir_err + 4'h1;
         end
      end

      // run command without drive answer
      if (!run_cmd || drive_active_in) begin
         nxt_st.drive_wait = 12'h000;
      end else if (tick && st_ff.drive_wait != DRV_TICKS) begin
         nxt_st.drive_wait = st_ff.drive_wait + 12'h001;
      end

      // display latch: a new fault beats a clear in the same cycle
      if (|ev) begin
         nxt_st.code = pick_code(ev);
         nxt_st.active = 1'b1;
      end else if (fault_clear) begin
         nxt_st.code = `LFS_CODE_NONE;
         nxt_st.active = 1'b0;
      end

      // recalibration run to the bottom floor at inspection speed
      case (st_ff.recal)
         RC_IDLE: begin
            if (ev[`LFS_EV_COUNT] || ev[`LFS_EV_FLOOR]) begin
               nxt_st.recal = RC_RUN;
            end
         end
         RC_RUN: begin
            // a fresh floor fault at the bottom keeps the run requested
            if (bottom_floor_in && !car_running && !ev[`LFS_EV_COUNT] && !ev[`LFS_EV_FLOOR]) begin
               nxt_st.recal = RC_IDLE;
            end
         end
         default: nxt_st.recal = RC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign fault_code = st_ff.code;
   assign fault_active = st_ff.active;
   assign recal_req = st_ff.recal == RC_RUN;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_code(logic trig, logic [7:0] c);
      trig && $onehot(ev) |=> fault_active && fault_code == c;
   endproperty

   sequence s_clear;
      fault_clear && !(|ev);
   endsequence

   sequence s_raise;
      |ev;
   endsequence

   chk_door_open_run: assert property (
      p_code($rose(car_running && !door_lock_in), `LFS_CODE_DOOR))
      else $error("door open in run not shown as 2");
   chk_drive_fault_code: assert property (
      p_code($rose(drive_fault_in), `LFS_CODE_DRIVE))
      else $error("drive fault not shown as 3");
   chk_safety_open: assert property (
      p_code($rose(!safety_loop_in_a && !safety_loop_in_b), `LFS_CODE_SAFETY))
      else $error("open safety loop not shown as 10");
   chk_top_limit: assert property (
      p_code($fell(top_limit_in), `LFS_CODE_TOP))
      else $error("top limit pass not shown as 12");
   chk_bottom_limit: assert property (
      p_code($fell(bottom_limit_in), `LFS_CODE_BOTTOM))
      else $error("bottom limit pass not shown as 13");
   chk_wrong_direction: assert property (
      p_code(wrong_dir && st_ff.dir_err == DIR_M1, `LFS_CODE_DIR))
      else $error("reverse travel not shown as 4");
   chk_short_pulses: assert property (
      p_code(run_end && st_ff.run_pulses < expected_pulses, `LFS_CODE_PULSE))
      else $error("short pulse count not shown as 7");
   chk_brake_switch_off: assert property (
      !brake_fb_enable && $past(brake_fb_enable) == 1'b0 |-> !ev[`LFS_EV_BRAKE])
      else $error("brake fault raised while checking is off");
   chk_invalid_floor: assert property (
      $rose(floor_number >= FLOORS) |=> recal_req)
      else $error("invalid floor did not start recalibration");
   chk_recal_hold: assert property (
      recal_req && !bottom_floor_in |=> recal_req)
      else $error("recalibration dropped before bottom floor");
   chk_clear_latch: assert property (
      s_raise ##1 s_clear |=> !fault_active && fault_code == `LFS_CODE_NONE)
      else $error("clear did not empty the display");
   chk_latch_hold: assert property (
      fault_active && !fault_clear |=> fault_active)
      else $error("latched fault vanished without clear");

endmodule
`default_nettype wire
